// File: rtl/sbs_pkg.sv
// Shared constants and types of the synchronous burst static RAM block.
// Assumes one rising-edge clock; every user of it imports sbs_pkg::*.
//
// How it works
// - Active edge, load, no write, all selects on: load address, begin read.
// - Continue cycle ignores write and selects; keeps current burst type.
// - Output control high on a read beat gives a dummy read, bus undriven.
// - Write beats never drive the bus, whatever the output control says.
// - Load, write low, selected, some lane enabled: load address, begin write.
// - Write low with every lane masked is an abort: no write, no drive.
// - Masked write continue skips storing but still advances the counter.
// - Load with any select inactive deselects and leaves the bus undriven.
// - Clock gate high makes the edge ignored; all state but the sleep sequencer and the first-edge strap capture holds.
// - Stalled pipelined read keeps driving; stalled write keeps bus undriven.
// - Two-bit burst counter steps on every continue cycle.
// - Step high uses counter address; step low loads the external address.
// - Counter wraps after four addresses; fifth beat repeats the start.
// - Linear order adds the beat count modulo four to the start.
// - Interleaved order XORs the beat count into the start bits.
// - Straps default to pipeline and low drive; low bypass gives flow-through.
// - All outputs stay undriven from power-up until normal operation.
// - Pipeline read data appears after the edge following the command.
// - Flow-through read data follows the command edge; write data next edge.
// - Sleep entered two cycles after request high, left two after low.
package sbs_pkg;

    // Data word layout: four byte lanes of nine bits.
    localparam int unsigned SBS_LANES = 4;
    localparam int unsigned SBS_LANE_W = 9;
    localparam int unsigned SBS_DATA_W = SBS_LANES * SBS_LANE_W;

    // Default word address width of the flip-flop storage.
    localparam int unsigned SBS_ADDR_W = 6;

    // Burst counter width and its unit step.
    localparam int unsigned SBS_BURST_W = 2;
    localparam logic [SBS_BURST_W-1:0] SBS_BEAT_ZERO = 2'h0;
    localparam logic [SBS_BURST_W-1:0] SBS_BEAT_ONE = 2'h1;

    // Clock cycles from a sleep request change to the mode change.
    localparam int unsigned SBS_SLEEP_CYC = 2;

    // Kind of burst in progress.
    typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITE} sbs_burst_t;

endpackage

// File: rtl/sbs_burst_addr.sv
// Burst address generator: start address register and two-bit counter.
// Assumes load and step already include the clock gate and are exclusive.
`timescale 1ns/1ns
`default_nettype none
module sbs_burst_addr
    import sbs_pkg::*;
#(
    parameter int unsigned ADDR_W = SBS_ADDR_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic step,
    input wire logic interleave,
    input wire logic [ADDR_W-1:0] addrIn,
    output logic [ADDR_W-1:0] accessAddr
);

    logic [ADDR_W-1:0] base_reg;
    logic [SBS_BURST_W-1:0] beat_reg;
    logic [SBS_BURST_W-1:0] beat_next;

    // Refuse an address no wider than the burst bits.
    if (ADDR_W <= SBS_BURST_W)
    begin : g_chk
        $error("sbs_burst_addr: ADDR_W must exceed the burst width.");
    end

    // Low address bits for a beat, in linear or interleaved order.
    function automatic logic [SBS_BURST_W-1:0] burst_low(
        input logic [SBS_BURST_W-1:0] start,
        input logic [SBS_BURST_W-1:0] beat,
        input logic il
    );
        burst_low = il ? (start ^ beat) : (start + beat);
    endfunction

    // The counter wraps by width, so beat four reuses the start bits.
    assign beat_next = beat_reg + SBS_BEAT_ONE;

    // A load uses the pins directly; a step uses the counter address.
    always_comb
    begin
        if (load)
        begin
            accessAddr = addrIn;
        end
        else
        begin
            accessAddr = {base_reg[ADDR_W-1:SBS_BURST_W],
                burst_low(base_reg[SBS_BURST_W-1:0], beat_next,
                interleave)};
        end
    end

    // Start address and beat count; both hold when neither strobe is on.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            base_reg <= '0;
            beat_reg <= SBS_BEAT_ZERO;
        end
        else if (load)
        begin
            base_reg <= addrIn;
            beat_reg <= SBS_BEAT_ZERO;
        end
        else if (step)
        begin
            beat_reg <= beat_next;
        end
    end

endmodule
`default_nettype wire

// File: rtl/sbs_sleep_ctl.sv
// Sleep mode sequencer: follows the sleep request after a settle delay.
// Assumes the request is already synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
module sbs_sleep_ctl
    import sbs_pkg::*;
#(
    parameter int unsigned SETTLE = SBS_SLEEP_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sleepReq,
    output logic asleep
);

    localparam int unsigned CW = $clog2(SETTLE + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE - 1);

    logic [CW-1:0] settle_reg;

    if (SETTLE < 1)
    begin : g_chk
        $error("sbs_sleep_ctl: SETTLE must be at least one.");
    end

    // Count cycles the request differs from the mode, then flip the mode.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            settle_reg <= '0;
            asleep <= 1'b0;
        end
        else if (sleepReq == asleep)
        begin
            settle_reg <= '0;
        end
        else if (settle_reg == LAST)
        begin
            settle_reg <= '0;
            asleep <= sleepReq;
        end
        else
        begin
            settle_reg <= settle_reg + CW'(1);
        end
    end

endmodule
`default_nettype wire

// File: rtl/sbs_sync_burst_ctrl.sv
// Command decode, burst control, storage and data bus of the burst RAM.
// Assumes all pins are synchronous to clk; the bus wire is resolved outside.
`timescale 1ns/1ns
`default_nettype none
module sbs_sync_burst_ctrl
    import sbs_pkg::*;
#(
    parameter int unsigned ADDR_W = SBS_ADDR_W,
    parameter int unsigned LANES = SBS_LANES,
    parameter int unsigned LANE_W = SBS_LANE_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEnableN,
    input wire logic burstStep,
    input wire logic writeEnableN,
    input wire logic [LANES-1:0] laneMaskN,
    input wire logic chipSelLowA,
    input wire logic chipSelHigh,
    input wire logic chipSelLowB,
    input wire logic outDriveN,
    input wire logic sleepReq,
    input wire logic linearOrderN,
    input wire logic bypassOutRegN,
    input wire logic driveStrengthSel,
    input wire logic [ADDR_W-1:0] addrIn,
    input wire logic [LANES*LANE_W-1:0] dqIn,
    output logic [LANES*LANE_W-1:0] dqOut,
    output logic dqOe,
    output logic sleeping,
    output logic pipeMode,
    output logic lowDrive
);

    localparam int unsigned DATA_W = LANES * LANE_W;
    localparam int unsigned DEPTH = 2 ** ADDR_W;

    // Word read from the lane storage at the current beat address.
    wire [DATA_W-1:0] rdWord;

    // Strap capture.
    logic strapDone_reg;
    logic interleave_reg;

    // Command decode.
    logic active;
    logic selected;
    logic anyLane;
    logic isLoad;
    logic isCont;
    logic rdBegin;
    logic wrBegin;
    logic rdBeat;
    logic wrBeat;
    logic [ADDR_W-1:0] accessAddr;
    sbs_burst_t burst_reg;
    sbs_burst_t burst_next;

    // Read pipeline stage (pipeline mode only).
    logic rdPipeOe_reg;
    logic [DATA_W-1:0] rdPipeData_reg;

    // Late write stages.
    logic wr1Valid_reg;
    logic [ADDR_W-1:0] wr1Addr_reg;
    logic [LANES-1:0] wr1Mask_reg;
    logic wr2Valid_reg;
    logic [ADDR_W-1:0] wr2Addr_reg;
    logic [LANES-1:0] wr2Mask_reg;
    logic wrFire;
    logic [ADDR_W-1:0] wrAddr;
    logic [LANES-1:0] wrMask;

    if (DATA_W < 1 || ADDR_W <= SBS_BURST_W)
    begin : g_chk
        $error("sbs_sync_burst_ctrl: unsupported width parameters.");
    end

    // Straps are caught on the first edge after reset release.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strapDone_reg <= 1'b0;
            pipeMode <= 1'b1;
            lowDrive <= 1'b1;
            interleave_reg <= 1'b0;
        end
        else if (!strapDone_reg)
        begin
            strapDone_reg <= 1'b1;
            pipeMode <= bypassOutRegN;
            lowDrive <= driveStrengthSel;
            interleave_reg <= linearOrderN;
        end
    end

    // Sleep sequencer; its output register is the sleeping port.
    sbs_sleep_ctl #(
        .SETTLE(SBS_SLEEP_CYC)
    ) u_sleep (
        .clk(clk),
        .rst(rst),
        .sleepReq(sleepReq),
        .asleep(sleeping)
    );

    // An edge counts only when ungated, awake and past strap capture.
    assign active = !clkEnableN && !sleeping && strapDone_reg;
    assign selected = !chipSelLowA && chipSelHigh && !chipSelLowB;
    assign anyLane = !(&laneMaskN);
    assign isLoad = active && !burstStep;
    assign isCont = active && burstStep;
    assign rdBegin = isLoad && selected && writeEnableN;
    assign wrBegin = isLoad && selected && !writeEnableN && anyLane;

    // A continue beat repeats the burst type, ignoring write and selects.
    assign rdBeat = rdBegin || (isCont && burst_reg == SBS_READ);
    assign wrBeat = wrBegin
        || (isCont && burst_reg == SBS_WRITE && anyLane);

    // Burst type after this edge; aborts and deselects end the burst.
    always_comb
    begin
        burst_next = burst_reg;
        if (rdBegin)
        begin
            burst_next = SBS_READ;
        end
        else if (wrBegin)
        begin
            burst_next = SBS_WRITE;
        end
        else if (isLoad)
        begin
            burst_next = SBS_IDLE;
        end
    end

    // Burst kind register; a gated edge or sleep holds it.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            burst_reg <= SBS_IDLE;
        end
        else if (active)
        begin
            burst_reg <= burst_next;
        end
    end

    // Address generator steps on every continue, even masked ones.
    sbs_burst_addr #(
        .ADDR_W(ADDR_W)
    ) u_addr (
        .clk(clk),
        .rst(rst),
        .load(isLoad),
        .step(isCont),
        .interleave(interleave_reg),
        .addrIn(addrIn),
        .accessAddr(accessAddr)
    );

    // Pipeline read stage: data waits here for one more active edge.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdPipeOe_reg <= 1'b0;
            rdPipeData_reg <= '0;
        end
        else if (active)
        begin
            rdPipeOe_reg <= rdBeat && !outDriveN;
            rdPipeData_reg <= rdWord;
        end
    end

    // Bus drive; held on a gated edge, so a stalled read keeps driving.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dqOe <= 1'b0;
            dqOut <= '0;
        end
        else if (sleeping)
        begin
            dqOe <= 1'b0;
        end
        else if (active)
        begin
            if (pipeMode)
            begin
                dqOe <= rdPipeOe_reg;
                dqOut <= rdPipeData_reg;
            end
            else
            begin
                dqOe <= rdBeat && !outDriveN;
                dqOut <= rdWord;
            end
        end
    end

    // Write stages carry address and lane mask until the data edge.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr1Valid_reg <= 1'b0;
            wr1Addr_reg <= '0;
            wr1Mask_reg <= '1;
            wr2Valid_reg <= 1'b0;
            wr2Addr_reg <= '0;
            wr2Mask_reg <= '1;
        end
        else if (active)
        begin
            wr1Valid_reg <= wrBeat;
            wr1Addr_reg <= accessAddr;
            wr1Mask_reg <= laneMaskN;
            wr2Valid_reg <= wr1Valid_reg;
            wr2Addr_reg <= wr1Addr_reg;
            wr2Mask_reg <= wr1Mask_reg;
        end
    end

    // Flow-through takes data one edge late, pipeline two edges late.
    assign wrFire = active
        && (pipeMode ? wr2Valid_reg : wr1Valid_reg);
    assign wrAddr = pipeMode ? wr2Addr_reg : wr1Addr_reg;
    assign wrMask = pipeMode ? wr2Mask_reg : wr1Mask_reg;

    // Each lane keeps its own storage, so every array has a single writer.
    // A lane stores only when its mask bit is low.
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        logic [LANE_W-1:0] laneMem_reg [DEPTH];

        always_ff @(posedge clk)
        begin
            if (wrFire && !wrMask[g])
            begin
                laneMem_reg[wrAddr] <= dqIn[g*LANE_W +: LANE_W];
            end
        end

        // Read side of this lane, at the address of the current beat.
        assign rdWord[g*LANE_W +: LANE_W] = laneMem_reg[accessAddr];
    end

    // Checks of the command, bus and sleep behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_readBegin;
        rdBegin |=> burst_reg == SBS_READ;
    endproperty
    a_readBegin: assert property (p_readBegin)
        else $error("Read begin did not start a read burst.");

    property p_contKeeps;
        isCont |=> burst_reg == $past(burst_reg);
    endproperty
    a_contKeeps: assert property (p_contKeeps)
        else $error("Continue cycle changed the burst type.");

    property p_dummyRead;
        !pipeMode && rdBeat && outDriveN && !sleeping |=> !dqOe;
    endproperty
    a_dummyRead: assert property (p_dummyRead)
        else $error("Dummy read drove the bus.");

    property p_writeQuiet;
        wrFire |-> !dqOe;
    endproperty
    a_writeQuiet: assert property (p_writeQuiet)
        else $error("Bus driven while write data is taken.");

    property p_abort;
        isLoad && selected && !writeEnableN && !anyLane
            |=> burst_reg == SBS_IDLE && !wr1Valid_reg;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Write abort started a write.");

    property p_deselect;
        isLoad && !selected |=> burst_reg == SBS_IDLE;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("Deselect left a burst running.");

    property p_stall;
        strapDone_reg && !sleeping && clkEnableN && !$rose(sleeping)
            |=> $stable(burst_reg) && $stable(dqOe) && $stable(dqOut);
    endproperty
    a_stall: assert property (p_stall)
        else $error("Gated edge changed state or bus.");

    property p_pipeRead;
        pipeMode && rdBegin && !outDriveN
            ##1 (active && !sleepReq) |=> dqOe;
    endproperty
    a_pipeRead: assert property (p_pipeRead)
        else $error("Pipeline read data not driven one edge late.");

    property p_flowRead;
        !pipeMode && rdBegin && !outDriveN |=> dqOe;
    endproperty
    a_flowRead: assert property (p_flowRead)
        else $error("Flow-through read data not driven at once.");

    property p_sleepEnter;
        $rose(sleeping) |-> $past(sleepReq) && $past(sleepReq, 2);
    endproperty
    a_sleepEnter: assert property (p_sleepEnter)
        else $error("Sleep entered without two request cycles.");

    property p_sleepQuiet;
        sleeping |=> !dqOe;
    endproperty
    a_sleepQuiet: assert property (p_sleepQuiet)
        else $error("Bus driven while asleep.");

    property p_pipeWrite;
        pipeMode && wrBegin ##1 active ##1 active |-> wrFire;
    endproperty
    a_pipeWrite: assert property (p_pipeWrite)
        else $error("Pipeline write not taken at the third edge.");

    c_readBurst: cover property (rdBegin ##1 rdBeat [*3]);
    c_writeBurst: cover property (wrBegin ##1 wrBeat [*3]);
    c_stallRead: cover property (dqOe && clkEnableN);
    c_sleep: cover property ($rose(sleeping) ##[1:20] $fell(sleeping));
    c_writeAbort: cover property (isLoad && selected && !writeEnableN
        && !anyLane);

endmodule
`default_nettype wire

// File: bench/sbs_host_bus.sv
// Host-side bus model: resolves the shared data wire of both ends.
// Assumes the bench plays the host command side.
`timescale 1ns/1ns
`default_nettype none
module sbs_host_bus
    import sbs_pkg::*;
(
    input wire logic clk,
    input wire logic hostOe,
    input wire logic [SBS_DATA_W-1:0] hostData,
    input wire logic dqOe,
    input wire logic [SBS_DATA_W-1:0] dqOut,
    output logic [SBS_DATA_W-1:0] dqIn,
    output logic clash
);
    logic [SBS_DATA_W-1:0] busLast_reg = '0;

    // A driver wins; a released wire toggles so stale data never matches.
    always_comb
    begin
        if (dqOe)
            dqIn = dqOut;
        else if (hostOe)
            dqIn = hostData;
        else
            dqIn = ~busLast_reg;
    end

    // Both ends driving at once is a turnaround fault.
    assign clash = dqOe && hostOe;

    // Last wire level, kept to build the floating pattern.
    always @(posedge clk)
        busLast_reg <= dqIn;
endmodule
`default_nettype wire

// File: bench/sbs_sync_burst_ctrl_tb.sv
// Self-checking bench of the burst RAM block with random bursts.
// Assumes the package and the host bus model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sbs_sync_burst_ctrl_tb
    import sbs_pkg::*;
;
    typedef struct packed {logic [1:0] k; logic [5:0] a;
        logic [3:0] m; logic o;} sbs_ent_t;
    logic clk = 1'h0, rst = 1'h1, clkEnableN = 1'h1, burstStep = 1'h0;
    logic writeEnableN = 1'h1, outDriveN = 1'h0, sleepReq = 1'h0;
    logic chipSelLowA = 1'h1, chipSelHigh = 1'h0, chipSelLowB = 1'h1;
    logic linearOrderN = 1'h0, bypassOutRegN = 1'h1;
    logic driveStrengthSel = 1'h1, hostOe = 1'h0;
    logic [3:0] laneMaskN = 4'hf;
    logic [5:0] addrIn = 6'h00;
    logic [SBS_DATA_W-1:0] hostData = '0;
    logic [SBS_DATA_W-1:0] dqIn, dqOut;
    logic dqOe, sleeping, pipeMode, lowDrive, clash;
    logic [SBS_DATA_W-1:0] refMem [64];
    logic [31:0] seed = 32'hb1fd_35e8;
    logic [5:0] bStart;
    logic [1:0] bBeat, bKind;
    logic ft, il;
    sbs_ent_t pe [2];
    int failCount = 0;
    int comparisons = 0;

    // Clock of 40 ns period.
    always #20 clk = ~clk;

    // Design and the bus partner.
    sbs_sync_burst_ctrl sbs_sync_burst_ctrl_inst (.clk(clk), .rst(rst),
        .clkEnableN(clkEnableN), .burstStep(burstStep),
        .writeEnableN(writeEnableN), .laneMaskN(laneMaskN),
        .chipSelLowA(chipSelLowA), .chipSelHigh(chipSelHigh),
        .chipSelLowB(chipSelLowB), .outDriveN(outDriveN),
        .sleepReq(sleepReq), .linearOrderN(linearOrderN),
        .bypassOutRegN(bypassOutRegN), .driveStrengthSel(driveStrengthSel),
        .addrIn(addrIn), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
        .sleeping(sleeping), .pipeMode(pipeMode), .lowDrive(lowDrive));
    sbs_host_bus sbs_host_bus_inst (.clk(clk), .hostOe(hostOe),
        .hostData(hostData), .dqOe(dqOe), .dqOut(dqOut), .dqIn(dqIn),
        .clash(clash));

    // Xorshift source of stimulus.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Burst address: start plus beat, or start XOR beat when interleaved.
    function automatic logic [5:0] beatAddr(input logic [5:0] s,
        input logic [1:0] n);
        return {s[5:2], il ? s[1:0] ^ n : s[1:0] + n};
    endfunction

    // Word after a write beat: only lanes with a low mask take new data.
    function automatic logic [SBS_DATA_W-1:0] merge(
        input logic [SBS_DATA_W-1:0] old, nw, input logic [3:0] m);
        for (int g = 0; g < 4; g++)
            if (!m[g])
                old[9*g +: 9] = nw[9*g +: 9];
        return old;
    endfunction

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [SBS_DATA_W-1:0] seen,
        input logic [SBS_DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (failCount == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Resets with the given straps and checks what was captured.
    task automatic doReset(input logic f, input logic i, input logic d);
        ft = f;
        il = i;
        bKind = 2'h0;
        pe[0] = '0;
        pe[1] = '0;
        rst = 1'h1;
        bypassOutRegN = !f;
        linearOrderN = i;
        driveStrengthSel = d;
        repeat (8) @(negedge clk);
        chk("dqOe", dqOe, 0);
        rst = 1'h0;
        @(negedge clk);
        chk("pipeMode", pipeMode, !f);
        chk("lowDrive", lowDrive, d);
    endtask

    // One cycle: check the beat now due, feed late write data, then
    // drive op 0 read, 1 write, 2 continue, 3 deselect or 4 stall.
    task automatic issue(input int op, input logic [5:0] a,
        input logic [3:0] m);
        logic [31:0] r;
        sbs_ent_t e;
        r = rnd();
        e = ft ? pe[0] : pe[1];
        @(negedge clk);
        chk("busClash", clash, 0);
        chk("dqOe", dqOe, e.k == 2'h1 && !e.o);
        if (e.k == 2'h1 && !e.o)
            chk("dqOut", dqOut, refMem[e.a]);
        hostOe = e.k == 2'h2;
        hostData = {r, r[3:0]};
        if (e.k == 2'h2)
            refMem[e.a] = merge(refMem[e.a], hostData, e.m);
        clkEnableN = op == 4;
        burstStep = op == 2 || (op == 4 && r[4]);
        writeEnableN = op > 1 ? r[5] : op == 0;
        laneMaskN = m;
        outDriveN = r[6];
        addrIn = a;
        {chipSelLowA, chipSelHigh, chipSelLowB} = op == 3 ?
            3'h2 ^ (3'h4 >> (a % 3)) : (op > 1 ? r[9:7] : 3'h2);
        if (op == 4)
            return;
        pe[1] = pe[0];
        if (op == 2)
        begin
            bBeat = bBeat + 2'h1;
            pe[0] = '{bKind, beatAddr(bStart, bBeat), m, r[6]};
        end
        else
        begin
            bStart = a;
            bBeat = 2'h0;
            bKind = op == 0 ? 2'h1 :
                (op == 1 && m != 4'hf ? 2'h2 : 2'h0);
            pe[0] = '{bKind, a, m, r[6]};
        end
    endtask

    // A load then n continues; rm gives random masks and stalls.
    task automatic burst(input int op, input logic [5:0] a, input int n,
        input logic rm);
        logic [31:0] r;
        r = rnd();
        issue(op, a, !rm ? 4'h0 : (r[2:0] == 3'h0 ? 4'hf : r[6:3]));
        repeat (n)
        begin
            r = rnd();
            issue(rm && r[2:0] == 3'h0 ? 4 : 2, r[15:10], rm ? r[6:3] : 4'h0);
        end
        issue(3, r[21:16], 4'h0);
        issue(3, r[27:22], 4'h0);
    endtask

    // Pipeline with linear order, then flow-through with interleave,
    // then a sleep request that must ignore commands and keep contents.
    initial
    begin
        logic [31:0] r;
        int n;
        for (int c = 0; c < 2; c++)
        begin
            doReset(c[0], c[0], !c[0]);
            for (int w = 0; w < 16; w++)
                burst(1, {w[3:0], 2'h0}, 3, 1'h0);
            for (int b = 0; b < 40; b++)
            begin
                r = rnd();
                n = r[1:0] == 2'h3 ? 3 : int'(r[0]);
                burst(n, {n == 0, r[12:8]}, int'(r[5:2]) % 7, 1'h1);
            end
            for (int w = 0; w < 16; w++)
            begin
                r = rnd();
                burst(0, {w[3:0], r[1:0]}, 4, 1'h1);
            end
        end
        sleepReq = 1'h1;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (sleeping !== 1'h1 && n < 8);
        chk("sleepEntry", n, 2);
        if (n >= 8)
            close_out();
        {burstStep, writeEnableN, laneMaskN} = '0;
        {chipSelLowA, chipSelHigh, chipSelLowB} = 3'h2;
        hostOe = 1'h1;
        hostData = ~refMem[0];
        addrIn = 6'h00;
        repeat (3)
        begin
            @(negedge clk);
            chk("dqOe", dqOe, 0);
        end
        {chipSelLowA, chipSelHigh, chipSelLowB} = 3'h6;
        hostOe = 1'h0;
        sleepReq = 1'h0;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (sleeping !== 1'h0 && n < 8);
        chk("sleepExit", n, 2);
        burst(0, 6'h00, 0, 1'h0);
        close_out();
    end
endmodule
`default_nettype wire
